/* tdtm_pkg.sv */
// Constants shared by the dual 8-bit timer/event counter block
package tdtm_pkg;
    localparam int          DATA_W            = 8;
    localparam int          ADDR_W            = 16;
    localparam int          SRC_W             = 4;
    localparam int          DIV_W             = 12;
    localparam int          EXP_W             = 4;
    localparam int          NUM_RATES         = 13;

    localparam logic [15:0] ADDR_MATCH_A      = 16'hff50;
    localparam logic [15:0] ADDR_COUNT_A      = 16'hff51;
    localparam logic [15:0] ADDR_SRC_A        = 16'hff52;
    localparam logic [15:0] ADDR_MODE_A       = 16'hff53;
    localparam logic [15:0] ADDR_MATCH_B      = 16'hff54;
    localparam logic [15:0] ADDR_COUNT_B      = 16'hff55;
    localparam logic [15:0] ADDR_SRC_B        = 16'hff56;
    localparam logic [15:0] ADDR_MODE_B       = 16'hff57;

    localparam logic [7:0]  MATCH_RESET       = 8'h00;
    localparam logic [7:0]  COUNT_RESET       = 8'h00;
    localparam logic [7:0]  SRC_RESET         = 8'h00;
    localparam logic [7:0]  MODE_RESET        = 8'h00;
    localparam logic [7:0]  READ_UNMAPPED     = 8'h00;

    // Mode control fields
    localparam int          MODE_RUN_BIT      = 7;
    localparam int          MODE_PWM_BIT      = 6;
    localparam int          MODE_SET_BIT      = 3;
    localparam int          MODE_CLR_BIT      = 2;
    localparam int          MODE_LVL_BIT      = 1;
    localparam int          MODE_OE_BIT       = 0;
    localparam logic [7:0]  MODE_READ_MASK    = 8'hc3;
    localparam logic [7:0]  SRC_READ_MASK     = 8'h0f;

    // Count source codes
    localparam logic [3:0]  SRC_PIN_FALL      = 4'h0;
    localparam logic [3:0]  SRC_PIN_RISE      = 4'h1;
    localparam logic [3:0]  SRC_DOUBLE        = 4'h4;
    localparam logic [3:0]  SRC_DIV_LAST      = 4'he;
    localparam logic [3:0]  SRC_SLOWEST       = 4'hf;
    localparam logic [3:0]  EXP_SLOWEST       = 4'hb;
    localparam logic [3:0]  EXP_BASE_OFFSET   = 4'h5;
endpackage

/* tdtm_channel.sv */
// One 8-bit timer/event counter channel with compare, interval and PWM output
`timescale 1ns/100ps
`default_nettype none
module tdtm_channel
    import tdtm_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic [NUM_RATES-1:0] i_rate_tick,
    input  wire logic                 i_clock_mode_bit,
    input  wire logic [SRC_W-1:0]     i_src,
    input  wire logic [DATA_W-1:0]    i_match,
    input  wire logic [DATA_W-1:0]    i_mode,
    input  wire logic                 i_ff_set,
    input  wire logic                 i_ff_clr,
    input  wire logic                 i_event_pin,
    output logic      [DATA_W-1:0]    o_count,
    output logic                      o_irq,
    output logic                      o_timer_out,
    output logic                      o_timer_out_en
);
    logic             sync_1;
    logic             sync_2;
    logic             sync_3;
    logic             pin_edge;
    logic             int_tick;
    logic             count_en;
    logic             is_match;
    logic             external;
    logic             run;
    logic             pwm;
    logic             out_ff;
    logic [EXP_W-1:0] rate_exp;

    assign run = i_mode[MODE_RUN_BIT];
    assign pwm = i_mode[MODE_PWM_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Event pin synchroniser; only sync_2 onward is looked at
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
            sync_3 <= 1'b0;
        end else begin
            sync_1 <= i_event_pin;
            sync_2 <= sync_1;
            sync_3 <= sync_2;
        end
    end

    // One pulse per qualifying edge (see RULE21, see RULE12)
    assign pin_edge = (i_src == SRC_PIN_RISE) ? (sync_2 & ~sync_3) : (~sync_2 & sync_3);
    assign external = (i_src == SRC_PIN_FALL) || (i_src == SRC_PIN_RISE);

    ////////////////////////////////////////////////////////////////////////
    // Rate exponent relative to the system clock (see RULE13, see RULE14)
    always_comb begin
        rate_exp = '0;
        int_tick = 1'b0;
        if (i_src == SRC_SLOWEST) begin
            rate_exp = EXP_SLOWEST + {3'h0, ~i_clock_mode_bit};
            int_tick = i_rate_tick[rate_exp];
        end else if (i_src >= SRC_DOUBLE && i_src <= SRC_DIV_LAST) begin
            // Doubled rate with the mode bit set cannot exceed the system clock
            if (i_src == SRC_DOUBLE && i_clock_mode_bit) begin
                rate_exp = '0;
            end else begin
                rate_exp = i_src - EXP_BASE_OFFSET + {3'h0, ~i_clock_mode_bit};
            end
            int_tick = i_rate_tick[rate_exp];
        end
    end

    // Prohibited codes leave the counter idle
    assign count_en = external ? pin_edge : int_tick;
    assign is_match = (o_count == i_match);    // see RULE5

    ////////////////////////////////////////////////////////////////////////
    // Counter
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_count <= COUNT_RESET;                 // see RULE9
        end else if (!run) begin
            o_count <= COUNT_RESET;                 // see RULE20
        end else if (count_en) begin
            if (!pwm && is_match) begin
                o_count <= COUNT_RESET;             // see RULE18, see RULE19
            end else begin
                o_count <= o_count + 8'h01;         // see RULE1
            end
        end
    end

    // Match request, one cycle per counted match (see RULE3)
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= run & count_en & is_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flip-flop: software set/clear, toggles on match when enabled
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            out_ff <= 1'b0;
        end else if (i_ff_set) begin
            out_ff <= 1'b1;
        end else if (i_ff_clr) begin
            out_ff <= 1'b0;
        end else if (run && !pwm && count_en && is_match && i_mode[MODE_LVL_BIT]) begin
            out_ff <= ~out_ff;
        end
    end

    // Pin output; not driven while counting pin edges (see RULE16)
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_timer_out    <= 1'b0;
            o_timer_out_en <= 1'b0;
        end else begin
            o_timer_out_en <= i_mode[MODE_OE_BIT] & ~external;
            if (pwm) begin
                // Active while count is below match: 8-bit duty (see RULE2)
                o_timer_out <= (run && (o_count < i_match)) ^ i_mode[MODE_LVL_BIT];
            end else begin
                o_timer_out <= out_ff;
            end
        end
    end
endmodule
`default_nettype wire

/* tdtm_top.sv */
// Dual 8-bit timer/event counter: byte register port, prescaler, two channels
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE1 - Two independent channels, each an 8-bit up-counter with 8-bit match value.
// RULE2 - Each channel can drive 8-bit resolution PWM on its timer output.
// RULE3 - Counter equal to match value raises that channel's interrupt request.
// RULE4 - Match values load by byte writes only; word writes are ignored.
// RULE5 - Match values accept every value from zero to all ones.
// RULE6 - Reset clears both match values to zero.
// RULE7 - Software loads the match value before selecting PWM mode.
// RULE8 - Each counter reads back as a byte holding the current count.
// RULE9 - Reset clears both counters to zero.
// RULE10 - Source select written by bytes; upper nibble reads zero, lower holds code.
// RULE11 - Reset clears both source selects, choosing event pin falling edges.
// RULE12 - Code 0000 counts pin falling edges, 0001 counts rising edges.
// RULE13 - Codes 0100 to 1110 give doubled, plain, divided clocks; 1111 divides by 2^11.
// RULE14 - Internal clock is full rate with mode bit 1, half with 0.
// RULE15 - Clock mode bit is bit 0 of the oscillation mode select register.
// RULE16 - Timer output is unused while counting external pin edges.
// RULE17 - Software stops a channel before changing its source select.
// RULE18 - Interval mode clears counter on match and keeps counting.
// RULE19 - Mode control picks clear-on-match or free-running PWM per channel.
// RULE20 - Clearing run control stops counting and forces counter to zero.
// RULE21 - Pin edges are synchronised and advance the counter exactly once.
// RULE22 - Prescaler is a free-running divider giving single-cycle rate enables.
module tdtm_top
    import tdtm_pkg::*;
(
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_sys_rst,
    input  wire logic [tdtm_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    input  wire logic                      i_word,
    input  wire logic [tdtm_pkg::DATA_W-1:0] i_wdata,
    output logic      [tdtm_pkg::DATA_W-1:0] o_rdata,
    input  wire logic                      i_osc_mode_select_bit0,
    input  wire logic                      i_event_input_a,
    input  wire logic                      i_event_input_b,
    output logic                           o_match_irq_a,
    output logic                           o_match_irq_b,
    output logic                           o_timer_output_a,
    output logic                           o_timer_output_a_en,
    output logic                           o_timer_output_b,
    output logic                           o_timer_output_b_en
);
    import tdtm_pkg::*;

    logic [DATA_W-1:0]    match_value   [2];
    logic [DATA_W-1:0]    count_value   [2];
    logic [SRC_W-1:0]     count_source  [2];
    logic [DATA_W-1:0]    mode_control  [2];
    logic [1:0]           ff_set;
    logic [1:0]           ff_clr;
    logic [1:0]           irq;
    logic [1:0]           tout;
    logic [1:0]           tout_en;
    logic [1:0]           event_in;
    logic [DIV_W-1:0]     prescale;
    logic [NUM_RATES-1:0] rate_tick;
    logic                 clock_mode_bit;
    logic [ADDR_W-1:0]    match_addr    [2];
    logic [ADDR_W-1:0]    count_addr    [2];
    logic [ADDR_W-1:0]    src_addr      [2];
    logic [ADDR_W-1:0]    mode_addr     [2];

    assign clock_mode_bit = i_osc_mode_select_bit0;   // see RULE15
    assign event_in       = {i_event_input_b, i_event_input_a};
    assign match_addr[0]  = ADDR_MATCH_A;
    assign match_addr[1]  = ADDR_MATCH_B;
    assign count_addr[0]  = ADDR_COUNT_A;
    assign count_addr[1]  = ADDR_COUNT_B;
    assign src_addr[0]    = ADDR_SRC_A;
    assign src_addr[1]    = ADDR_SRC_B;
    assign mode_addr[0]   = ADDR_MODE_A;
    assign mode_addr[1]   = ADDR_MODE_B;

    ////////////////////////////////////////////////////////////////////////
    // Free-running prescaler; all-ones in the low k bits lasts one cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 12'h001;         // see RULE22
        end
    end

    assign rate_tick[0] = 1'b1;
    genvar k;
    generate
        for (k = 1; k < NUM_RATES; k++) begin : g_rate
            assign rate_tick[k] = &prescale[k-1:0]; // see RULE22
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Per-channel registers and counters
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_chan
            // Word accesses never load the match value (see RULE4)
            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    match_value[c] <= MATCH_RESET;              // see RULE6
                end else if (i_wr && !i_word && i_addr == match_addr[c]) begin
                    match_value[c] <= i_wdata;                  // see RULE5
                end
            end

            // Changing the code while running is not guarded (see RULE17)
            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    count_source[c] <= SRC_RESET[SRC_W-1:0];    // see RULE11
                end else if (i_wr && !i_word && i_addr == src_addr[c]) begin
                    count_source[c] <= i_wdata[SRC_W-1:0];      // see RULE10
                end
            end

            // Set/clear bits act once and are not stored
            always_ff @(posedge i_sys_clk) begin
                if (i_sys_rst) begin
                    mode_control[c] <= MODE_RESET;
                    ff_set[c]       <= 1'b0;
                    ff_clr[c]       <= 1'b0;
                end else begin
                    ff_set[c] <= 1'b0;
                    ff_clr[c] <= 1'b0;
                    if (i_wr && !i_word && i_addr == mode_addr[c]) begin
                        mode_control[c] <= i_wdata & MODE_READ_MASK; // see RULE19
                        ff_set[c] <= i_wdata[MODE_SET_BIT] & ~i_wdata[MODE_CLR_BIT];
                        ff_clr[c] <= i_wdata[MODE_CLR_BIT] & ~i_wdata[MODE_SET_BIT];
                    end
                end
            end

            tdtm_channel u_chan (
                .i_sys_clk        (i_sys_clk),
                .i_sys_rst        (i_sys_rst),
                .i_rate_tick      (rate_tick),
                .i_clock_mode_bit (clock_mode_bit),
                .i_src            (count_source[c]),
                .i_match          (match_value[c]),
                .i_mode           (mode_control[c]),
                .i_ff_set         (ff_set[c]),
                .i_ff_clr         (ff_clr[c]),
                .i_event_pin      (event_in[c]),
                .o_count          (count_value[c]),
                .o_irq            (irq[c]),
                .o_timer_out      (tout[c]),
                .o_timer_out_en   (tout_en[c])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read port: data registered one cycle after the read strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rdata <= READ_UNMAPPED;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_MATCH_A: o_rdata <= match_value[0];
                ADDR_MATCH_B: o_rdata <= match_value[1];
                ADDR_COUNT_A: o_rdata <= count_value[0];                // see RULE8
                ADDR_COUNT_B: o_rdata <= count_value[1];                // see RULE8
                ADDR_SRC_A:   o_rdata <= {4'h0, count_source[0]};       // see RULE10
                ADDR_SRC_B:   o_rdata <= {4'h0, count_source[1]};       // see RULE10
                ADDR_MODE_A:  o_rdata <= mode_control[0] & MODE_READ_MASK;
                ADDR_MODE_B:  o_rdata <= mode_control[1] & MODE_READ_MASK;
                default:      o_rdata <= READ_UNMAPPED;
            endcase
        end
    end

    // Outputs come straight from channel flops, re-registered here
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_match_irq_a       <= 1'b0;
            o_match_irq_b       <= 1'b0;
            o_timer_output_a    <= 1'b0;
            o_timer_output_a_en <= 1'b0;
            o_timer_output_b    <= 1'b0;
            o_timer_output_b_en <= 1'b0;
        end else begin
            o_match_irq_a       <= irq[0];                      // see RULE3
            o_match_irq_b       <= irq[1];                      // see RULE3
            o_timer_output_a    <= tout[0];
            o_timer_output_a_en <= tout_en[0];                  // see RULE16
            o_timer_output_b    <= tout[1];
            o_timer_output_b_en <= tout_en[1];                  // see RULE16
        end
    end
endmodule
`default_nettype wire

/* tdtm_properties.sv */
// Port-level checker for the dual timer/event counter
`timescale 1ns/100ps
`default_nettype none
module tdtm_properties
    import tdtm_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_word,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_osc_mode_select_bit0,
    input  wire logic [7:0]  o_rdata,
    input  wire logic        o_match_irq_a,
    input  wire logic        o_timer_output_a_en
);
    import tdtm_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    logic [7:0] match_a;
    logic [7:0] mode_a;
    logic [3:0] src_a;
    logic [8:0] gap;
    logic       seen;
    wire  logic wr_ok  = i_wr && !i_word;
    // Only interval mode on every-cycle ticks gives a period we can predict
    wire  logic steady = mode_a[7] && !mode_a[6] && src_a == SRC_DOUBLE && !i_osc_mode_select_bit0;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            match_a <= 8'h00;
            mode_a  <= 8'h00;
            src_a   <= 4'h0;
        end else if (wr_ok && i_addr == ADDR_MATCH_A) begin
            match_a <= i_wdata;
        end else if (wr_ok && i_addr == ADDR_MODE_A) begin
            mode_a <= i_wdata;
        end else if (wr_ok && i_addr == ADDR_SRC_A) begin
            src_a <= i_wdata[3:0];
        end
    end

    // Any write may disturb the phase, so the gap restarts
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || i_wr || !steady) begin
            seen <= 1'b0;
            gap  <= 9'h000;
        end else if (o_match_irq_a) begin
            seen <= 1'b1;
            gap  <= 9'h001;
        end else begin
            gap <= gap + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_rdata_hold: assert property (!$past(i_rd) |-> $stable(o_rdata))
        else $error("read data changed without a read");
    a_src_upper_zero: assert property ($past(i_rd) && $past(i_addr) == ADDR_SRC_A
        |-> o_rdata == {4'h0, $past(src_a)}) else $error("source select readback wrong");
    a_match_readback: assert property ($past(i_rd)
        && $past(i_addr) == ADDR_MATCH_A |-> o_rdata == $past(match_a))
        else $error("match value readback wrong");
    // Read data shows the count of one edge back, which saw run of two edges back
    a_stopped_count_zero: assert property ($past(i_rd)
        && $past(i_addr) == ADDR_COUNT_A && !$past(mode_a[7], 2) |-> o_rdata == 8'h00)
        else $error("stopped count not zero");
    a_pin_src_no_out: assert property (src_a[3:1] == 3'h0
        && $past(src_a[3:1], 2) == 3'h0 |-> !o_timer_output_a_en)
        else $error("output enabled on pin source");
    a_out_en_follows: assert property (src_a >= SRC_DOUBLE && mode_a[0]
        && $past(mode_a, 3) == mode_a && $past(src_a, 3) == src_a
        |-> o_timer_output_a_en) else $error("timer output not enabled");
    a_match_period: assert property (o_match_irq_a && seen
        |-> gap == {1'b0, match_a} + 9'h001) else $error("match interrupt period wrong");
    a_irq_one_cycle: assert property (o_match_irq_a && seen && match_a != 8'h00
        |=> !o_match_irq_a) else $error("match interrupt longer than one cycle");
endmodule
bind tdtm_top tdtm_properties u_tdtm_properties (.i_sys_clk, .i_sys_rst, .i_addr, .i_wr, .i_rd,
    .i_word, .i_wdata, .i_osc_mode_select_bit0, .o_rdata, .o_match_irq_a, .o_timer_output_a_en);
`default_nettype wire

/* tdtm_pin_model.sv */
// Behavioural model of the event input and timer output pins
`timescale 1ns/100ps
`default_nettype none
module tdtm_pin_model (
    input  wire logic i_sys_clk,
    input  wire logic i_timer_output_a,
    input  wire logic i_timer_output_a_en,
    output logic      o_event_input_a,
    output logic      o_event_input_b
);
    initial begin
        o_event_input_a = 1'b1;
        o_event_input_b = 1'b1;
    end

    // Both pins pulse together: one falling and one rising edge per pulse
    task automatic pulse(input int n, input int half);
        repeat (n) begin
            @(posedge i_sys_clk);
            o_event_input_a <= 1'b0;
            o_event_input_b <= 1'b0;
            repeat (half) @(posedge i_sys_clk);
            o_event_input_a <= 1'b1;
            o_event_input_b <= 1'b1;
            repeat (half - 1) @(posedge i_sys_clk);
        end
    endtask

    // Counts cycles in which the pin is driven high
    task automatic measure(input int n, output logic [15:0] hi);
        hi = 16'h0000;
        repeat (n) begin
            @(posedge i_sys_clk);
            hi = hi + {15'h0000, i_timer_output_a & i_timer_output_a_en};
        end
    endtask

    // Holds both pins at one level from the next clock edge
    task automatic level(input logic v);
        @(posedge i_sys_clk);
        o_event_input_a <= v;
        o_event_input_b <= v;
    endtask
endmodule
`default_nettype wire

/* tb_tdtm_top.sv */
// Self-checking bench for the dual timer/event counter
`timescale 1ns/100ps
`default_nettype none
module tb_tdtm_top;
    import tdtm_pkg::*;
    logic        i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_word = 1'b0;
    logic        i_osc_mode_select_bit0 = 1'b0;
    logic [15:0] i_addr = 16'h0000, hi;
    logic [7:0]  i_wdata = 8'h00, o_rdata;
    wire  logic  i_event_input_a, i_event_input_b;
    logic        o_match_irq_a, o_match_irq_b, o_timer_output_a, o_timer_output_a_en;
    logic        o_timer_output_b, o_timer_output_b_en;
    int          errors = 0, checked = 0, n;

    tdtm_top u_tdtm_top (.i_sys_clk, .i_sys_rst, .i_addr, .i_wr, .i_rd, .i_word, .i_wdata,
        .o_rdata, .i_osc_mode_select_bit0, .i_event_input_a, .i_event_input_b, .o_match_irq_a,
        .o_match_irq_b, .o_timer_output_a, .o_timer_output_a_en, .o_timer_output_b,
        .o_timer_output_b_en);
    tdtm_pin_model u_tdtm_pin_model (.i_sys_clk, .i_timer_output_a(o_timer_output_a),
        .i_timer_output_a_en(o_timer_output_a_en), .o_event_input_a(i_event_input_a),
        .o_event_input_b(i_event_input_b));

    always #25 i_sys_clk = ~i_sys_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic w = 1'b0);
        @(posedge i_sys_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_word  <= w;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string what);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(posedge i_sys_clk);
        #1;
        chk(what, {8'h00, o_rdata}, {8'h00, e});
    endtask
    // Cycles between two match pulses of channel b, bounded
    task automatic irq_gap(output int g);
        for (int k = 0; k < 9000 && o_match_irq_b !== 1'b1; k++) @(posedge i_sys_clk);
        g = 0;
        do begin
            @(posedge i_sys_clk);
            g++;
        end while (o_match_irq_b !== 1'b1 && g < 9000);
    endtask
    function automatic int rate_exp(input int code, input logic osc);
        if (code == 4) return 0;
        return (code == 15 ? 11 : code - 5) + (osc ? 0 : 1);
    endfunction
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        errors++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        for (int a = 0; a < 9; a++) begin
            rd(16'hff50 + a[15:0], 8'h00, "reset");
        end
        $display("Test reset values done");
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_MATCH_A, 8'h5a ^ (8'h55 << i));
            wr(ADDR_MATCH_B, ~(8'h5a ^ (8'h55 << i)));
            rd(ADDR_MATCH_A, 8'h5a ^ (8'h55 << i), "match a");
            rd(ADDR_MATCH_B, ~(8'h5a ^ (8'h55 << i)), "match b");
        end
        wr(ADDR_MATCH_A, 8'h3c, 1'b1);
        rd(ADDR_MATCH_A, 8'h5a ^ 8'h54, "match word write");
        wr(ADDR_SRC_B, 8'hf7);
        rd(ADDR_SRC_B, 8'h07, "source b");
        $display("Test registers done");
        wr(ADDR_MATCH_A, 8'h02);
        wr(ADDR_SRC_A, {4'h0, SRC_DOUBLE});
        wr(ADDR_MODE_A, 8'h80);
        repeat (20) @(posedge i_sys_clk);
        n = 0;
        repeat (30) begin
            @(posedge i_sys_clk);
            n += int'(o_match_irq_a === 1'b1);
        end
        chk("interval pulses", n[15:0], 16'h000a);
        wr(ADDR_MODE_A, 8'h00);
        rd(ADDR_COUNT_A, 8'h00, "stopped count");
        for (int c = 2; c < 4; c++) begin
            wr(ADDR_SRC_A, c[7:0]);
            wr(ADDR_MODE_A, 8'h80);
            repeat (40) @(posedge i_sys_clk);
            rd(ADDR_COUNT_A, 8'h00, "prohibited code");
            wr(ADDR_MODE_A, 8'h00);
        end
        $display("Test interval done");
        wr(ADDR_MATCH_A, 8'hff);
        wr(ADDR_MATCH_B, 8'hff);
        rd(ADDR_MATCH_A, 8'hff, "match max");
        wr(ADDR_SRC_A, {4'h0, SRC_PIN_FALL});
        wr(ADDR_SRC_B, {4'h0, SRC_PIN_RISE});
        wr(ADDR_MODE_A, 8'h81);
        wr(ADDR_MODE_B, 8'h81);
        u_tdtm_pin_model.pulse(5, 4);
        u_tdtm_pin_model.pulse(3, 1);
        // One extra fall so the two polarities end on different counts
        u_tdtm_pin_model.level(1'b0);
        repeat (8) @(posedge i_sys_clk);
        rd(ADDR_COUNT_A, 8'h09, "falling edges");
        rd(ADDR_COUNT_B, 8'h08, "rising edges");
        chk("pin source outputs", {13'h0000, o_timer_output_a_en, o_timer_output_b_en,
            o_timer_output_b}, 16'h0000);
        wr(ADDR_MODE_A, 8'h00);
        $display("Test event pins done");
        wr(ADDR_MATCH_A, 8'h40);
        wr(ADDR_SRC_A, {4'h0, SRC_DOUBLE});
        wr(ADDR_MODE_A, 8'hc1);
        repeat (300) @(posedge i_sys_clk);
        u_tdtm_pin_model.measure(512, hi);
        chk("pwm high cycles", hi, 16'h0080);
        wr(ADDR_MODE_A, 8'h00);
        wr(ADDR_MATCH_B, 8'h00);
        $display("Test pwm done");
        for (int osc = 0; osc < 2; osc++) begin
            for (int c = 4; c < 16; c++) begin
                if (osc == 1 && c == 4) continue;
                wr(ADDR_MODE_B, 8'h00);
                i_osc_mode_select_bit0 <= osc[0];
                wr(ADDR_SRC_B, c[7:0]);
                wr(ADDR_MODE_B, 8'h80);
                irq_gap(n);
                chk("rate", n[15:0], 16'h1 << rate_exp(c, osc[0]));
            end
        end
        $display("Test count rates done");
        stop_test();
    end
endmodule
`default_nettype wire
